// >>> rtl/adcsf_device.sv
// converter end: conversion, serial output and offset calibration on the link clock
`timescale 1ns/1ps
`default_nettype none
module adcsf_device (
   // link
   adcsf_link_if.device_end link,
   // power-up reset
   input wire logic rst,
   // analog inputs, as levels in lsb units
   input wire logic [9:0] positive_analog_input,
   input wire logic [9:0] negative_analog_input,
   // intrinsic offset of the sampling stage, signed lsb
   input wire logic [5:0] zero_input_error,
   // sampling stage isolated from the inputs
   output logic input_disconnected
);
   import adcsf_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [5:0] edges;
      logic [9:0] sar;
      logic sdo;
      logic cal_active;
      logic [5:0] cal_meas;
   } adcsf_frame_type;

   adcsf_frame_type frame;
   adcsf_frame_type next_frame;

   // ************************************************************
   // capture state, held for the whole frame
   // ************************************************************
   typedef struct packed {
      logic signed [12:0] sample;
      logic cal_frame;
      logic powered;
   } adcsf_capture_type;

   adcsf_capture_type cap;
   adcsf_capture_type next_cap;

   // ************************************************************
   // offset store and helpers
   // ************************************************************
   logic [5:0] offset_correction_store;
   logic [5:0] next_store;
   logic store_load;
   logic frame_clear;
   logic [9:0] target_code;
   logic [9:0] trial;
   logic [9:0] trial_bit;
   logic [5:0] fall_no;
   logic [3:0] out_idx;
   logic powerup_isolate;

   // ************************************************************
   // sign extension of a six-bit offset onto the level scale
   // ************************************************************
   // shared by the stage error and the stored offset
   function automatic logic signed [12:0] adcsf_widen(input logic [5:0] value);
      logic signed [12:0] wide;
      wide = $signed({{7{value[5]}}, value});
      return wide;
   endfunction

   // ************************************************************
   // sample capture on chip select fall
   // ************************************************************
   always_comb begin
      next_cap = cap;
      // straight binary difference plus the stage's own error
      next_cap.sample = $signed({3'h0, positive_analog_input})
         - $signed({3'h0, negative_analog_input})
         + adcsf_widen(zero_input_error);
      next_cap.cal_frame = ~cap.powered;
      next_cap.powered = 1'b1;
   end

   // the sample is frozen at select fall, so the inputs may move in the frame
   always_ff @(negedge link.cs_n or posedge rst) begin
      if (rst) begin
         cap <= '0;
      end else begin
         cap <= next_cap;
      end
   end

   // ************************************************************
   // frame logic, clocked by falling serial clock
   // ************************************************************
   // the clock stops between frames, so the frame ends through the
   // chip select level acting as an asynchronous clear
   assign frame_clear = rst | link.cs_n;

   // ************************************************************
   // corrected code
   // ************************************************************
   // the clamp keeps a large stored offset from wrapping the scale
   always_comb begin
      target_code = adcsf_clamp_code(cap.sample
         - adcsf_widen(offset_correction_store));
   end

   // ************************************************************
   // counter, word and calibration windows
   // ************************************************************

   always_comb begin
      next_frame = frame;
      store_load = 1'b0;
      trial_bit = SAR_FIRST_BIT >> frame.edges[3:0];
      trial = frame.sar | trial_bit;
      out_idx = 4'h0;
      // edge count saturates so very long frames stay quiet
      if (frame.edges != EDGE_SATURATE) begin
         next_frame.edges = frame.edges + 6'h01;
      end
      fall_no = next_frame.edges;

      // ************************************************************
      // successive approximation, one decision per falling edge for the first ten falls
      // ************************************************************
      if (frame.edges < 6'(RES_BITS)) begin
         if (trial <= target_code) begin
            next_frame.sar = trial;
         end
      end

      // ************************************************************
      // serial word: second zero, then result msb first, then low
      // ************************************************************
      next_frame.sdo = 1'b0;
      if (cap.cal_frame) begin
         next_frame.sdo = 1'b0;
      end else if (fall_no == EDGE_SECOND_ZERO) begin
         next_frame.sdo = 1'b0;
      end else if (fall_no < EDGE_RESULT_DONE) begin
         out_idx = 4'(WORD_BITS - 1) - fall_no[3:0];
         next_frame.sdo = frame.sar[out_idx];
      end else begin
         next_frame.sdo = 1'b0;
      end

      // ************************************************************
      // calibration windows
      // ************************************************************
      if (cap.cal_frame) begin
         if (fall_no == EDGE_SECOND_ZERO) begin
            next_frame.cal_active = 1'b1;
            next_frame.cal_meas = zero_input_error;
         end else if (fall_no == EDGE_POWERUP_CAL_END && frame.cal_active) begin
            next_frame.cal_active = 1'b0;
            store_load = 1'b1;
         end
      end else begin
         if (fall_no == EDGE_CAL_START) begin
            next_frame.cal_active = 1'b1;
            next_frame.cal_meas = zero_input_error;
         end else if (fall_no == EDGE_CAL_END && frame.cal_active) begin
            next_frame.cal_active = 1'b0;
            store_load = 1'b1;
         end
      end
   end

   always_ff @(negedge link.sclk or posedge frame_clear) begin
      if (frame_clear) begin
         frame <= '0;
      end else begin
         frame <= next_frame;
      end
   end

   // ************************************************************
   // offset store, survives frames, cleared only by power-up
   // ************************************************************
   always_comb begin
      next_store = offset_correction_store;
      // a frame cut short never reaches the load edge
      if (store_load) begin
         next_store = frame.cal_meas;
      end
   end

   // only a power cycle, standing as rst here, brings the store back to zero
   always_ff @(negedge link.sclk or posedge rst) begin
      if (rst) begin
         offset_correction_store <= OFFSET_STORE_RESET;
      end else begin
         offset_correction_store <= next_store;
      end
   end

   // ************************************************************
   // pins
   // ************************************************************
   // the enable follows chip select directly so the first zero is
   // on the line at the falling edge without waiting for a clock
   assign link.sdo = frame.sdo;
   assign link.sdo_oe = ~link.cs_n;

   // ************************************************************
   // input isolation
   // ************************************************************
   // the first frame isolates from select fall, before any clock arrives
   assign powerup_isolate = cap.cal_frame & ~link.cs_n;
   assign input_disconnected = powerup_isolate | frame.cal_active;
endmodule
`default_nettype wire

// >>> rtl/adcsf_pkg.sv
// constants and shared decoding for the serial converter frame and offset calibration
//
// Operation
// - frame runs from chip select fall to rise
// - host waits setup before first clock fall
// - serial clock steps conversion and shifting
// - word is two zeros then ten bits
// - first zero driven at chip select fall
// - later bits launched on clock falling edges
// - output low after twelfth fall until deselect
// - chip select rise ends frame, releases output
// - host allows acquisition time between frames
// - codes follow ideal transfer characteristic
// - first frame after power-up calibrates, output low
// - power-up calibration needs sixteen falling edges
// - short first frame leaves offset store unchanged
// - host waits acquisition time after calibration
// - offset store clears at power-up, hidden
// - inputs disconnected while calibration runs
// - later results corrected by stored offset
// - thirty-two edges in one frame recalibrate
// - long-frame calibration runs edge 17 to 32
// - shorter frames never update offset store
// - host limits clock rate during calibration
// - host recalibrates at power-up and on drift
// - straight binary, zero input gives zero code
package adcsf_pkg;

   // ************************************************************
   // word layout and codes
   // ************************************************************
   localparam int RES_BITS = 10;
   localparam int WORD_BITS = 12;
   localparam logic [9:0] LOWEST_OUTPUT_CODE = 10'h000;
   localparam logic [9:0] MIDDLE_OUTPUT_CODE = 10'h200;
   localparam logic [9:0] HIGHEST_OUTPUT_CODE = 10'h3ff;
   localparam logic [9:0] SAR_FIRST_BIT = 10'h200;
   localparam logic [5:0] OFFSET_STORE_RESET = 6'h00;

   // ************************************************************
   // falling-edge counts within a frame
   // ************************************************************
   localparam logic [5:0] EDGE_SECOND_ZERO = 6'h01;
   localparam logic [5:0] EDGE_RESULT_DONE = 6'h0c;
   localparam logic [5:0] EDGE_POWERUP_CAL_END = 6'h10;
   localparam logic [5:0] EDGE_CAL_START = 6'h11;
   localparam logic [5:0] EDGE_CAL_END = 6'h20;
   localparam logic [5:0] EDGE_SATURATE = 6'h3f;
   localparam logic [5:0] FRAME_NORMAL_EDGES = 6'h0c;
   localparam logic [5:0] FRAME_POWERUP_EDGES = 6'h10;
   localparam logic [5:0] FRAME_RECAL_EDGES = 6'h20;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_SYS_PERIOD_NS = 20;
   localparam int SETUP_NS = 15;
   localparam int ACQ_NS = 235;
   localparam int SETUP_CYC = (SETUP_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
   localparam int ACQ_CYC = (ACQ_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
   // half period of 4 cycles gives 6.25 mhz, under the lower calibration limit
   localparam int HALF_CYC = (SETUP_CYC > 4) ? SETUP_CYC : 4;

   // ************************************************************
   // shared decoding
   // ************************************************************
   // clamp a signed level in lsb units onto the 10-bit straight binary scale
   function automatic logic [9:0] adcsf_clamp_code(input logic signed [12:0] level);
      logic [9:0] code;
      code = LOWEST_OUTPUT_CODE;
      if (level <= 13'sd0) begin
         code = LOWEST_OUTPUT_CODE;
      end else if (level >= 13'sd1023) begin
         code = HIGHEST_OUTPUT_CODE;
      end else begin
         code = level[9:0];
      end
      return code;
   endfunction

endpackage

// >>> rtl/adcsf_link_if.sv
// serial link between host and converter: chip select, serial clock, data out
`timescale 1ns/1ps
`default_nettype none
interface adcsf_link_if;
   logic cs_n;
   logic sclk;
   logic sdo;
   logic sdo_oe;

   modport device_end (
      input cs_n,
      input sclk,
      output sdo,
      output sdo_oe
   );

   modport host_end (
      output cs_n,
      output sclk,
      input sdo,
      input sdo_oe
   );
endinterface
`default_nettype wire

// >>> rtl/adcsf_sync.sv
// three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
`default_nettype none
module adcsf_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // asynchronous level in, filtered level out
   input wire logic d,
   output logic q
);
   import adcsf_pkg::*;

   typedef struct packed {
      logic ff1;
      logic ff2;
      logic ff3;
      logic q;
   } adcsf_sync_type;

   adcsf_sync_type st;
   adcsf_sync_type next_st;

   always_comb begin
      next_st = st;
      next_st.ff1 = d;
      next_st.ff2 = st.ff1;
      next_st.ff3 = st.ff2;
      // ff1 feeds only ff2; the filter looks at the later stages
      if (st.ff2 == st.ff3) begin
         next_st.q = st.ff3;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.q;
endmodule
`default_nettype wire

// >>> rtl/adcsf_host.sv
// host end: makes chip select and serial clock, collects results, runs calibration frames
`timescale 1ns/1ps
`default_nettype none
module adcsf_host (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // link
   adcsf_link_if.host_end link,
   // requests
   input wire logic start,
   input wire logic recalibrate,
   // status and results
   output logic ready,
   output logic [9:0] result,
   output logic result_valid
);
   import adcsf_pkg::*;

   typedef enum {
      H_IDLE,
      H_HIGH,
      H_LOW,
      H_ACQ
   } adcsf_hstate_type;

   typedef struct packed {
      adcsf_hstate_type state;
      logic [4:0] div;
      logic [5:0] edges;
      logic [5:0] target;
      logic [11:0] shreg;
      logic cs_n;
      logic sclk;
      logic cal_only;
      logic powered;
      logic ready;
      logic [9:0] result;
      logic result_valid;
   } adcsf_host_type;

   adcsf_host_type st;
   adcsf_host_type next_st;
   logic sdo_sync;

   adcsf_sync u_sdo_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d(link.sdo),
      .q(sdo_sync)
   );

   always_comb begin
      next_st = st;
      next_st.result_valid = 1'b0;
      next_st.div = st.div + 5'h01;
      case (st.state)
         H_IDLE: begin
            next_st.div = 5'h00;
            next_st.ready = st.powered;
            if (!st.powered || start) begin
               next_st.cs_n = 1'b0;
               next_st.edges = 6'h00;
               next_st.ready = 1'b0;
               next_st.state = H_HIGH;
               next_st.cal_only = ~st.powered;
               if (!st.powered) begin
                  next_st.target = FRAME_POWERUP_EDGES;
               end else if (recalibrate) begin
                  next_st.target = FRAME_RECAL_EDGES;
               end else begin
                  next_st.target = FRAME_NORMAL_EDGES;
               end
            end
         end
         H_HIGH: begin
            // first high phase doubles as the setup wait after select
            if (st.div == 5'(HALF_CYC - 1)) begin
               next_st.div = 5'h00;
               if (st.edges == st.target) begin
                  next_st.cs_n = 1'b1;
                  next_st.state = H_ACQ;
                  if (!st.cal_only) begin
                     next_st.result = st.shreg[9:0];
                     next_st.result_valid = 1'b1;
                  end
               end else begin
                  if (st.edges < EDGE_RESULT_DONE) begin
                     next_st.shreg = {st.shreg[10:0], sdo_sync};
                  end
                  next_st.sclk = 1'b0;
                  next_st.edges = st.edges + 6'h01;
                  next_st.state = H_LOW;
               end
            end
         end
         H_LOW: begin
            if (st.div == 5'(HALF_CYC - 1)) begin
               next_st.div = 5'h00;
               next_st.sclk = 1'b1;
               next_st.state = H_HIGH;
            end
         end
         H_ACQ: begin
            // covers acquisition and chip select high time
            if (st.div == 5'(ACQ_CYC - 1)) begin
               next_st.div = 5'h00;
               next_st.powered = 1'b1;
               next_st.ready = 1'b1;
               next_st.state = H_IDLE;
            end
         end
         default: begin
            next_st.state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '{state: H_IDLE, div: 5'h00, edges: 6'h00, target: 6'h00,
                 shreg: 12'h000, cs_n: 1'b1, sclk: 1'b1, cal_only: 1'b0,
                 powered: 1'b0, ready: 1'b0, result: 10'h000, result_valid: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign link.cs_n = st.cs_n;
   assign link.sclk = st.sclk;
   assign ready = st.ready;
   assign result = st.result;
   assign result_valid = st.result_valid;
endmodule
`default_nettype wire

// >>> tb/adcsf_link_monitor.sv
// checker for the serial link between host and converter
`timescale 1ns/1ps
`default_nettype none
module adcsf_link_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdo,
   input wire logic sdo_oe
);
   import adcsf_pkg::*;
   // ************************************************************
   // falls in the frame and time spent deselected
   // ************************************************************
   logic sclk_q;
   logic first;
   logic [5:0] cnt;
   logic [5:0] falls;
   logic [7:0] high_cnt;
   // falls counts a fall seen at this very sample as well
   assign falls = cnt + {5'h00, sclk_q & ~sclk};
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b1;
         first <= 1'b1;
         cnt <= 6'h00;
         high_cnt <= 8'hff;
      end else begin
         sclk_q <= sclk;
         if (cs_n) begin
            cnt <= 6'h00;
         end else if (falls != EDGE_SATURATE) begin
            cnt <= falls;
         end
         if (cs_n && cnt != 6'h00) begin
            first <= 1'b0;
         end
         // saturate so a long idle never wraps into a short one
         if (!cs_n) begin
            high_cnt <= 8'h00;
         end else if (high_cnt != 8'hff) begin
            high_cnt <= high_cnt + 8'h01;
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_setup;
      $fell(cs_n) |-> sclk [*4];
   endproperty
   a_setup: assert property (p_setup) else $error("clock fell too soon");
   property p_first_zero;
      $fell(cs_n) |-> sdo_oe && !sdo;
   endproperty
   a_first_zero: assert property (p_first_zero) else $error("no zero at select");
   property p_release;
      cs_n |-> !sdo_oe && !sdo;
   endproperty
   a_release: assert property (p_release) else $error("data driven while idle");
   property p_second_zero;
      !cs_n && !first && falls == EDGE_SECOND_ZERO |-> !sdo;
   endproperty
   a_second_zero: assert property (p_second_zero) else $error("second bit not zero");
   property p_launch;
      !cs_n && !$fell(cs_n) && falls == cnt |-> $stable(sdo);
   endproperty
   a_launch: assert property (p_launch) else $error("data moved off a fall");
   property p_tail;
      !cs_n && falls >= EDGE_RESULT_DONE |-> !sdo;
   endproperty
   a_tail: assert property (p_tail) else $error("data high after word");
   property p_cal_low;
      !cs_n && first |-> !sdo;
   endproperty
   a_cal_low: assert property (p_cal_low) else $error("data high in first frame");
   property p_cal_len;
      $rose(cs_n) && first |-> cnt >= FRAME_POWERUP_EDGES;
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("first frame too short");
   property p_frame_len;
      $rose(cs_n) && !first |-> cnt == FRAME_NORMAL_EDGES || cnt == FRAME_RECAL_EDGES;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("odd frame length");
   property p_acq;
      $fell(cs_n) |-> high_cnt >= ACQ_CYC;
   endproperty
   a_acq: assert property (p_acq) else $error("acquisition gap too short");
endmodule
`default_nettype wire

// >>> tb/adc_serial_frame_offset_cal_tb_top.sv
// bench joining host and converter, plus a converter driven by hand
`timescale 1ns/1ps
`default_nettype none
module adc_serial_frame_offset_cal_tb_top;
   import adcsf_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b0;
   logic start = 1'b0;
   logic recalibrate = 1'b0;
   logic [9:0] pos = 10'h000;
   logic [9:0] neg = 10'h000;
   logic [5:0] zerr = 6'h05;
   logic [9:0] pos2 = 10'h2a5;
   logic [9:0] neg2 = 10'h000;
   logic [5:0] zerr2 = 6'h07;
   logic ready;
   logic [9:0] result;
   logic result_valid;
   logic disc;
   logic disc2;
   logic [11:0] w;
   int failures = 0;
   int samples_checked = 0;
   adcsf_link_if u_link();
   adcsf_link_if u_link2();
   adcsf_host u_adcsf_host (.clk_sys(clk_sys), .rst(rst), .link(u_link), .start(start),
      .recalibrate(recalibrate), .ready(ready), .result(result), .result_valid(result_valid));
   adcsf_device u_adcsf_device (.link(u_link), .rst(rst), .positive_analog_input(pos),
      .negative_analog_input(neg), .zero_input_error(zerr), .input_disconnected(disc));
   adcsf_device u_adcsf_device_b (.link(u_link2), .rst(rst), .positive_analog_input(pos2),
      .negative_analog_input(neg2), .zero_input_error(zerr2), .input_disconnected(disc2));
   adcsf_link_monitor u_adcsf_link_monitor (.clk_sys(clk_sys), .rst(rst), .cs_n(u_link.cs_n),
      .sclk(u_link.sclk), .sdo(u_link.sdo), .sdo_oe(u_link.sdo_oe));
   always #10 clk_sys = ~clk_sys;
   // ************************************************************
   // compares and report
   // ************************************************************
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected bit at %0t", $time);
      end
   endtask
   task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected code %h at %0t", got, $time);
      end
   endtask
   task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected word %h at %0t", got, $time);
      end
   endtask
   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ************************************************************
   // host side conversion
   // ************************************************************
   task automatic conv(input logic [9:0] p, input logic [9:0] m, input logic rc,
      input logic [9:0] exp);
      int n;
      logic dis;
      n = 0;
      dis = 1'b0;
      while (ready !== 1'b1 || result_valid !== 1'b0) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > 3000) begin
            failures++;
            summarize();
         end
      end
      @(posedge clk_sys);
      pos <= p;
      neg <= m;
      recalibrate <= rc;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      n = 0;
      while (result_valid !== 1'b1) begin
         @(posedge clk_sys);
         #1;
         dis = dis | disc;
         n++;
         if (n > 1000) begin
            failures++;
            summarize();
         end
      end
      chk_code(result, exp);
      // after the power-up frame, only a long frame isolates the inputs
      chk_bit(dis, rc);
   endtask
   // ************************************************************
   // hand-driven frame on the second link, link clock 160 ns
   // ************************************************************
   task automatic frame2(input int n, input logic iso, output logic [11:0] wd);
      wd = 12'h000;
      #7;
      u_link2.cs_n = 1'b0;
      #1;
      chk_bit(u_link2.sdo_oe, 1'b1);
      chk_bit(u_link2.sdo, 1'b0);
      chk_bit(disc2, iso);
      #40;
      for (int i = 0; i < n; i++) begin
         if (i < 12) begin
            wd = {wd[10:0], u_link2.sdo};
         end
         u_link2.sclk = 1'b0;
         #80;
         u_link2.sclk = 1'b1;
         #80;
      end
      u_link2.cs_n = 1'b1;
      #1;
      chk_bit(u_link2.sdo_oe, 1'b0);
      #300;
   endtask
   initial begin
      rst <= 1'b1;
      u_link2.cs_n = 1'b1;
      u_link2.sclk = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      chk_bit(u_link.cs_n, 1'b1);
      chk_bit(ready, 1'b0);
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (20) @(posedge clk_sys);
      #1;
      chk_bit(u_link.cs_n, 1'b0);
      chk_bit(disc, 1'b1);
      conv(10'h000, 10'h000, 1'b0, 10'h000);
      conv(10'h200, 10'h000, 1'b0, 10'h200);
      conv(10'h3ff, 10'h000, 1'b0, 10'h3ff);
      conv(10'h155, 10'h000, 1'b0, 10'h155);
      conv(10'h005, 10'h00a, 1'b0, 10'h000);
      conv(10'h0c3, 10'h0c2, 1'b0, 10'h001);
      @(posedge clk_sys);
      zerr <= 6'h3d;
      conv(10'h100, 10'h000, 1'b0, 10'h0f8);
      conv(10'h100, 10'h000, 1'b1, 10'h0f8);
      conv(10'h100, 10'h000, 1'b0, 10'h100);
      // short first frame leaves the store at its cleared value
      frame2(8, 1'b1, w);
      chk_word(w, 12'h000);
      frame2(12, 1'b0, w);
      chk_word(w, 12'h2ac);
      summarize();
   end
endmodule
`default_nettype wire
